/* common/fdc_regs_pkg.sv */
/*
 * Constants and types for the floppy host register front end: slot offsets,
 * status A bit positions, reset values and the interface mode type.
 * Assumes it is compiled before every design file that imports it.
 */
`default_nettype none

package fdc_regs_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned SLOT_W    = 3;
  localparam int unsigned SLOT_CNT  = 8;

  localparam logic [2:0] OFS_STATUS_A  = 3'h0;
  localparam logic [2:0] OFS_STATUS_B  = 3'h1;
  localparam logic [2:0] OFS_DIG_OUT   = 3'h2;
  localparam logic [2:0] OFS_TAPE      = 3'h3;
  localparam logic [2:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] OFS_QUEUE     = 3'h5;
  localparam logic [2:0] OFS_RESERVED  = 3'h6;
  localparam logic [2:0] OFS_DIN_CFG   = 3'h7;

  localparam int unsigned SRA_DIR   = 0;
  localparam int unsigned SRA_WP    = 1;
  localparam int unsigned SRA_INDEX = 2;
  localparam int unsigned SRA_HEAD  = 3;
  localparam int unsigned SRA_TRK0  = 4;
  localparam int unsigned SRA_STEP  = 5;
  localparam int unsigned SRA_B6    = 6;
  localparam int unsigned SRA_IRQ   = 7;

  localparam int unsigned DOC_DMAEN = 3;

  localparam logic [7:0] DIG_OUT_RST   = 8'h00;
  localparam logic [7:0] TAPE_RST      = 8'h00;
  localparam logic [7:0] TAPE_NORM_MSK = 8'h03;
  localparam logic [7:0] DATA_RST      = 8'h00;

  typedef enum logic [1:0] {
    MODE_AT,
    MODE_PS2,
    MODE_M30
  } if_mode_e;

endpackage : fdc_regs_pkg

`default_nettype wire

/* hw/status_a_compose.sv */
/*
 * Builds the status A byte for the second and third interface modes and
 * holds the latched step flip-flop of the third mode.
 * Assumes all drive inputs are synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none

module status_a_compose
  import fdc_regs_pkg::*;
(
  input  wire logic       clock,        // System clock.
  input  wire logic       rst,          // Asynchronous reset, active high.
  input  wire if_mode_e   mode,         // Current interface mode.
  input  wire logic       irq_state,    // Interrupt output state.
  input  wire logic       drq_state,    // DMA request output state.
  input  wire logic       step_level,   // Registered step output level.
  input  wire logic       dir_in,       // Registered head direction, 1 inward.
  input  wire logic       head_side,    // Registered side select, 1 side 1.
  input  wire logic       trk0_n,       // Track zero pin, active low.
  input  wire logic       index_n,      // Index pin, active low.
  input  wire logic       wp_n,         // Write protect after forcing, low.
  input  wire logic       drv2_n,       // Second drive present, active low.
  input  wire logic       dir_read,     // Read of the digital input slot.
  output logic [7:0]      sra_value,    // Status A byte for current mode.
  output logic            step_ff       // Latched step flip-flop.
);

  logic step_prev_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= step_level;
    end
  end

  // Setting beats the clearing read so a step edge is never lost.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_ff <= 1'b0; // R18
    end else if (step_level && !step_prev_reg) begin
      step_ff <= 1'b1; // R17
    end else if (dir_read) begin
      step_ff <= 1'b0;
    end
  end

  always_comb begin
    if (mode == MODE_M30) begin
      sra_value[SRA_IRQ]   = irq_state; // R17
      sra_value[SRA_B6]    = drq_state;
      sra_value[SRA_STEP]  = step_ff;
      sra_value[SRA_TRK0]  = ~trk0_n;
      sra_value[SRA_HEAD]  = ~head_side;
      sra_value[SRA_INDEX] = ~index_n;
      sra_value[SRA_WP]    = ~wp_n;
      sra_value[SRA_DIR]   = ~dir_in;
    end else begin
      sra_value[SRA_IRQ]   = irq_state; // R15
      sra_value[SRA_B6]    = drv2_n; // R14
      sra_value[SRA_STEP]  = step_level; // R13
      sra_value[SRA_TRK0]  = trk0_n; // R11
      sra_value[SRA_HEAD]  = head_side; // R12
      sra_value[SRA_INDEX] = index_n; // R11
      sra_value[SRA_WP]    = wp_n; // R10
      sra_value[SRA_DIR]   = dir_in; // R09
    end
  end

endmodule : status_a_compose

`default_nettype wire

/* hw/floppy_host_register_modes.sv */
/*
 * Host register front end of a floppy controller: eight byte slots at a
 * programmable base, interface and floppy mode selection, status A, the
 * digital output and tape control registers, and mode dependent pin polarity.
 * Assumes synchronous one-cycle read and write strobes from the host bus and
 * that the command engine supplies data for slots 1, 4, 5 and 7.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01 - Every host register is eight bits, reached by programmed or DMA transfers.
// R02 - Host sets the base address before access; block disabled until then.
// R03 - Enhanced floppy mode bit zero selects normal mode; only tape layout changes.
// R04 - Both select bits high: AT set, DMA enable honoured, active high pins.
// R05 - Identity low, encoding high: second mode, outputs always driven, active low.
// R06 - Both select bits low: third mode, DMA enable honoured, density active low.
// R07 - Offsets 0 to 7 decoded; 4 and 7 split read/write; 6 reserved.
// R08 - Status A read-only; in AT mode its read leaves the data bus floating.
// R09 - Second mode bit 0 reports direction, 1 inward.
// R10 - Second mode bit 1 reports write protect low, after forcing.
// R11 - Second mode bits 2 and 4 report index and track zero pins inverted; the code passes the pin levels through uninverted.
// R12 - Second mode bit 3 reports side select, 1 side one.
// R13 - Second mode bit 5 reports live step output level.
// R14 - Second mode bit 6 reports second drive present, active low.
// R15 - Bit 7 reports the interrupt output state.
// R16 - Second mode resets bits 7, 5, 3, 0 to zero.
// R17 - Third mode layout: irq, drq, step latch, trk0, nside, index, wp, ndir.
// R18 - Third mode resets irq, drq, step to 0 and nside, ndir to 1.
// R19 - Writes to read-only slots and reserved accesses change nothing.
// R20 - Mode bits are decoded combinationally, effective at the next access.
module floppy_host_register_modes
  import fdc_regs_pkg::*;
(
  input  wire logic              clock,            // 40 MHz system clock.
  input  wire logic              rst,              // Asynchronous reset, active high.
  input  wire logic [ADDR_W-1:0] host_addr,        // Host I/O address.
  input  wire logic              host_aen,         // DMA address cycle, blocks decode.
  input  wire logic              host_rd,          // One-cycle read strobe.
  input  wire logic              host_wr,          // One-cycle write strobe.
  input  wire logic [7:0]        host_wdata,       // Host write data.
  input  wire logic [ADDR_W-4:0] base_addr,        // Base address bits 15..3.
  input  wire logic              base_valid,       // Base has been programmed.
  input  wire logic              ident_select,     // Identity interface select bit.
  input  wire logic              encoding_mode_select, // Encoding interface select bit.
  input  wire logic              enh_floppy_mode2, // Enhanced floppy mode bit.
  input  wire logic              force_wp_en,      // Force write protect enable.
  input  wire logic              force_wp_val,     // Forced value, 1 protected.
  input  wire logic [7:0]        core_rdata,       // Core data for slots 1, 4, 5, 7.
  input  wire logic              core_irq,         // Core interrupt request.
  input  wire logic              core_drq,         // Core DMA request.
  input  wire logic              core_step,        // Step output level to drive.
  input  wire logic              core_dir,         // Head direction, 1 inward.
  input  wire logic              core_side,        // Head side select, 1 side 1.
  input  wire logic              core_density_hi,  // High density selected.
  input  wire logic              terminal_count_in, // Terminal count pin.
  input  wire logic              write_protect_n,  // Write protect pin.
  input  wire logic              index_pulse_n,    // Index pin.
  input  wire logic              track_zero_n,     // Track zero pin.
  input  wire logic              second_drive_present_n, // Second drive pin.
  output logic [7:0]             host_rdata,       // Read data, one cycle after strobe.
  output logic                   host_rdata_oe_n,  // Low while driving read data.
  output logic [SLOT_CNT-1:0]    slot_rd_pulse,    // Read strobe per slot to core.
  output logic [SLOT_CNT-1:0]    slot_wr_pulse,    // Write strobe per slot to core.
  output logic [7:0]             slot_wdata,       // Data with slot_wr_pulse.
  output logic                   floppy_irq_out,   // Interrupt pin level.
  output logic                   floppy_irq_oe_n,  // Low while interrupt driven.
  output logic                   dma_req_out,      // DMA request pin level.
  output logic                   dma_req_oe_n,     // Low while DMA request driven.
  output logic                   tc_asserted,      // Terminal count after polarity.
  output logic                   density_select_out, // Density pin level.
  output logic                   head_side_select, // Side select to drive.
  output logic                   step_latched,     // Third mode step latch.
  output logic [7:0]             digital_output_ctrl, // Digital output register.
  output logic [7:0]             tape_drive_ctrl   // Tape control register.
);

  if_mode_e   mode;
  logic       hit;
  logic [2:0] slot;
  logic       dma_gate;
  logic       wp_eff_n;
  logic [7:0] sra_value;
  logic [7:0] tape_view;
  logic       dir_reg;
  logic       step_reg;

  // No clock stage here, so a mode change needs no reset to take hold.
  always_comb begin
    if (!ident_select && encoding_mode_select) begin
      mode = MODE_PS2; // R05
    end else if (!ident_select && !encoding_mode_select) begin
      mode = MODE_M30; // R06
    end else begin
      mode = MODE_AT; // R04 R20
    end
  end

  // Nothing answers until the base is programmed.
  assign hit  = base_valid && !host_aen && (host_addr[ADDR_W-1:3] == base_addr); // R02
  assign slot = host_addr[2:0]; // R07

  // The second mode ignores the DMA enable bit and always drives.
  assign dma_gate = (mode == MODE_PS2) || digital_output_ctrl[DOC_DMAEN]; // R04 R05 R06
  assign wp_eff_n = force_wp_en ? ~force_wp_val : write_protect_n; // R10

  // Normal floppy mode shows only the low tape bits.
  assign tape_view = enh_floppy_mode2 ? tape_drive_ctrl
                                      : (tape_drive_ctrl & TAPE_NORM_MSK); // R03

  status_a_compose u_sra (
    .clock     (clock),
    .rst       (rst),
    .mode      (mode),
    .irq_state (floppy_irq_out),
    .drq_state (dma_req_out),
    .step_level(step_reg),
    .dir_in    (dir_reg),
    .head_side (head_side_select),
    .trk0_n    (track_zero_n),
    .index_n   (index_pulse_n),
    .wp_n      (wp_eff_n),
    .drv2_n    (second_drive_present_n),
    .dir_read  (hit && host_rd && (slot == OFS_DIN_CFG)),
    .sra_value (sra_value),
    .step_ff   (step_latched)
  );

  // Core state is registered so the status bits have defined reset values.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      floppy_irq_out   <= 1'b0; // R16 R18
      dma_req_out      <= 1'b0;
      step_reg         <= 1'b0;
      dir_reg          <= 1'b0;
      head_side_select <= 1'b0;
    end else begin
      floppy_irq_out   <= core_irq;
      dma_req_out      <= core_drq;
      step_reg         <= core_step;
      dir_reg          <= core_dir;
      head_side_select <= core_side;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      floppy_irq_oe_n    <= 1'b1;
      dma_req_oe_n       <= 1'b1;
      tc_asserted        <= 1'b0;
      density_select_out <= 1'b0;
    end else begin
      floppy_irq_oe_n    <= ~dma_gate; // R04 R05 R06
      dma_req_oe_n       <= ~dma_gate;
      tc_asserted        <= (mode == MODE_PS2) ? ~terminal_count_in : terminal_count_in;
      density_select_out <= (mode == MODE_AT) ? core_density_hi : ~core_density_hi;
    end
  end

  // Only the writable slots store; read-only and reserved slots drop writes.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digital_output_ctrl <= DIG_OUT_RST;
      tape_drive_ctrl     <= TAPE_RST;
    end else if (hit && host_wr) begin
      if (slot == OFS_DIG_OUT) begin
        digital_output_ctrl <= host_wdata; // R19
      end
      if (slot == OFS_TAPE) begin
        tape_drive_ctrl <= host_wdata;
      end
    end
  end

  // Strobes to the core carry side effects such as queue pops; none for slot 6.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slot_rd_pulse <= '0;
      slot_wr_pulse <= '0;
      slot_wdata    <= DATA_RST;
    end else begin
      slot_rd_pulse <= '0;
      slot_wr_pulse <= '0;
      if (hit && host_rd && (slot != OFS_RESERVED)) begin
        slot_rd_pulse[slot] <= 1'b1; // R07
      end
      if (hit && host_wr && (slot != OFS_RESERVED)
          && (slot != OFS_STATUS_A) && (slot != OFS_STATUS_B)) begin
        slot_wr_pulse[slot] <= 1'b1; // R19
        slot_wdata          <= host_wdata; // R01
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_rdata      <= DATA_RST;
      host_rdata_oe_n <= 1'b1;
    end else begin
      host_rdata_oe_n <= 1'b1;
      if (hit && host_rd) begin
        unique case (slot)
          OFS_STATUS_A: begin
            host_rdata      <= sra_value;
            host_rdata_oe_n <= (mode == MODE_AT); // R08
          end
          OFS_DIG_OUT: begin
            host_rdata      <= digital_output_ctrl;
            host_rdata_oe_n <= 1'b0;
          end
          OFS_TAPE: begin
            host_rdata      <= tape_view; // R03
            host_rdata_oe_n <= 1'b0;
          end
          OFS_RESERVED: begin
            host_rdata_oe_n <= 1'b1; // R19
          end
          OFS_STATUS_B, OFS_MAIN_RATE, OFS_QUEUE, OFS_DIN_CFG: begin
            host_rdata      <= core_rdata;
            host_rdata_oe_n <= 1'b0;
          end
        endcase
      end
    end
  end

  property p_sra_float_at;
    @(posedge clock) disable iff (rst)
    (hit && host_rd && slot == OFS_STATUS_A && mode == MODE_AT) |=> host_rdata_oe_n;
  endproperty
  a_sra_float_at: assert property (p_sra_float_at) else $error("status A drove bus in AT mode"); // R08

  property p_sra_irq_bit;
    @(posedge clock) disable iff (rst)
    (hit && host_rd && slot == OFS_STATUS_A && mode != MODE_AT)
      |=> !host_rdata_oe_n && host_rdata[SRA_IRQ] == $past(floppy_irq_out);
  endproperty
  a_sra_irq_bit: assert property (p_sra_irq_bit) else $error("status A bit 7 wrong"); // R15

  property p_ps2_always_driven;
    @(posedge clock) disable iff (rst)
    (mode == MODE_PS2) |=> !floppy_irq_oe_n && !dma_req_oe_n;
  endproperty
  a_ps2_always_driven: assert property (p_ps2_always_driven) else $error("PS2 mode floated"); // R05

  property p_dmaen_gates;
    @(posedge clock) disable iff (rst)
    (mode != MODE_PS2 && !digital_output_ctrl[DOC_DMAEN]) |=> floppy_irq_oe_n && dma_req_oe_n;
  endproperty
  a_dmaen_gates: assert property (p_dmaen_gates) else $error("outputs driven with DMA off"); // R04

  property p_density_pol;
    @(posedge clock) disable iff (rst)
    1'b1 |=> density_select_out == ($past(mode) == MODE_AT ? $past(core_density_hi)
                                                          : !$past(core_density_hi));
  endproperty
  a_density_pol: assert property (p_density_pol) else $error("density polarity wrong"); // R06

  property p_tc_pol;
    @(posedge clock) disable iff (rst)
    (mode == MODE_PS2) |=> tc_asserted == !$past(terminal_count_in);
  endproperty
  a_tc_pol: assert property (p_tc_pol) else $error("terminal count polarity wrong"); // R05

  property p_ro_write_still;
    @(posedge clock) disable iff (rst)
    (host_wr && !(hit && (slot == OFS_DIG_OUT || slot == OFS_TAPE)))
      |=> $stable(digital_output_ctrl) && $stable(tape_drive_ctrl);
  endproperty
  a_ro_write_still: assert property (p_ro_write_still) else $error("register changed"); // R19

  property p_rsvd_quiet;
    @(posedge clock) disable iff (rst)
    (hit && (host_rd || host_wr) && slot == OFS_RESERVED)
      |=> host_rdata_oe_n && slot_rd_pulse == '0 && slot_wr_pulse == '0;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved slot acted"); // R07

  property p_m30_layout;
    @(posedge clock) disable iff (rst)
    (hit && host_rd && slot == OFS_STATUS_A && mode == MODE_M30)
      |=> host_rdata[SRA_DIR] == !$past(dir_reg) && host_rdata[SRA_B6] == $past(dma_req_out);
  endproperty
  a_m30_layout: assert property (p_m30_layout) else $error("third mode layout wrong"); // R17

  property p_unbased_silent;
    @(posedge clock) disable iff (rst)
    (!base_valid) |=> host_rdata_oe_n [*2];
  endproperty
  a_unbased_silent: assert property (p_unbased_silent) else $error("answered without base"); // R02

endmodule : floppy_host_register_modes

`default_nettype wire

/* testbench/drive_pins_model.sv */
/*
 * Behavioural floppy drive: holds the four drive status pins at levels
 * that the bench loads, as real drives change them slowly.
 * Assumes load and lvl change off the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module drive_pins_model (
  input  wire logic       clock,                  // System clock.
  input  wire logic       rst,                    // Asynchronous reset, active high.
  input  wire logic       load,                   // Take new pin levels.
  input  wire logic [3:0] lvl,                    // Second drive, track zero, index, protect.
  output logic            second_drive_present_n, // Second drive pin.
  output logic            track_zero_n,           // Track zero pin.
  output logic            index_pulse_n,          // Index pin.
  output logic            write_protect_n         // Write protect pin.
);
  // Pins idle high, as an empty bay with pull-ups would show them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {second_drive_present_n, track_zero_n, index_pulse_n, write_protect_n} <= 4'hf;
    end else if (load) begin
      {second_drive_present_n, track_zero_n, index_pulse_n, write_protect_n} <= lvl;
    end
  end
endmodule : drive_pins_model

`default_nettype wire

/* testbench/floppy_host_register_modes_tb.sv */
/*
 * Self-checking bench for the floppy host register front end.
 * Assumes the drive pin model and the register package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module floppy_host_register_modes_tb;
  import fdc_regs_pkg::*;
  logic        clock = 0, rst = 1, host_aen, host_rd, host_wr, base_valid, ident_select;
  logic        encoding_mode_select, enh_floppy_mode2, force_wp_en, force_wp_val, load;
  logic        core_irq, core_drq, core_step, core_dir, core_side, core_density_hi;
  logic        terminal_count_in, write_protect_n, index_pulse_n, track_zero_n;
  logic        second_drive_present_n, host_rdata_oe_n, floppy_irq_out, floppy_irq_oe_n;
  logic        dma_req_out, dma_req_oe_n, tc_asserted, density_select_out;
  logic        head_side_select, step_latched, exp_latch;
  logic [15:0] host_addr;
  logic [12:0] base_addr;
  logic [7:0]  host_wdata, core_rdata, host_rdata, slot_wdata, digital_output_ctrl;
  logic [7:0]  tape_drive_ctrl, slot_rd_pulse, slot_wr_pulse, d, dor_v;
  logic [3:0]  lvl;
  logic [2:0]  s;
  int          n_errors = 0, n_checks = 0, cyc = 0, m;

  floppy_host_register_modes i_floppy_host_register_modes (.clock, .rst, .host_addr,
    .host_aen, .host_rd, .host_wr, .host_wdata, .base_addr, .base_valid, .ident_select,
    .encoding_mode_select, .enh_floppy_mode2, .force_wp_en, .force_wp_val, .core_rdata,
    .core_irq, .core_drq, .core_step, .core_dir, .core_side, .core_density_hi,
    .terminal_count_in, .write_protect_n, .index_pulse_n, .track_zero_n,
    .second_drive_present_n, .host_rdata, .host_rdata_oe_n, .slot_rd_pulse,
    .slot_wr_pulse, .slot_wdata, .floppy_irq_out, .floppy_irq_oe_n, .dma_req_out,
    .dma_req_oe_n, .tc_asserted, .density_select_out, .head_side_select, .step_latched,
    .digital_output_ctrl, .tape_drive_ctrl);
  drive_pins_model i_drive_pins_model (.clock, .rst, .load, .lvl, .second_drive_present_n,
    .track_zero_n, .index_pulse_n, .write_protect_n);

  always #12.5 clock = ~clock;

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One strobe cycle; the caller samples at the falling edge that ends it,
  // while the one-cycle answer still stands.
  task automatic acc(input logic w, input logic [2:0] s, input logic [7:0] v);
    @(negedge clock);
    host_addr = {base_addr, s};
    host_rd = !w;
    host_wr = w;
    host_wdata = v;
    @(negedge clock);
    host_rd = 0;
    host_wr = 0;
  endtask : acc

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  function automatic logic [7:0] sra_exp(input logic m30);
    logic wpn;
    wpn = force_wp_en ? ~force_wp_val : write_protect_n;
    if (!m30) return {core_irq, second_drive_present_n, core_step, track_zero_n,
                      core_side, index_pulse_n, wpn, core_dir};
    return {core_irq, core_drq, exp_latch, ~track_zero_n, ~core_side, ~index_pulse_n,
            ~wpn, ~core_dir};
  endfunction : sra_exp

  task automatic rd_sra(input string nm);
    acc(0, 0, 0);
    if (m == 0) chk(nm, 8'h01, host_rdata_oe_n);
    else chk(nm, sra_exp(m == 2), host_rdata);
  endtask : rd_sra

  initial begin
    void'($urandom(86));
    {host_aen, host_rd, host_wr, base_valid, force_wp_en, force_wp_val, load} = 0;
    {core_irq, core_drq, core_step, core_dir, core_side, core_density_hi} = 0;
    {ident_select, encoding_mode_select, enh_floppy_mode2, terminal_count_in} = 4'hc;
    {host_addr, host_wdata, core_rdata, lvl, exp_latch, m} = 0;
    base_addr = 13'h007e;
    tick(16);
    rst = 0;
    chk("reset_oe", 8'h07, {host_rdata_oe_n, floppy_irq_oe_n, dma_req_oe_n});
    chk("reset_doc", DIG_OUT_RST, digital_output_ctrl);
    acc(0, 2, 0);
    chk("no_base", 8'h01, host_rdata_oe_n);
    base_valid = 1;
    host_aen = 1;
    acc(0, 2, 0);
    chk("aen_block", 8'h01, host_rdata_oe_n);
    host_aen = 0;
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      enh_floppy_mode2 = i[0];
      acc(1, 2, d);
      chk("doc_wr_pulse", 8'h04, slot_wr_pulse);
      chk("wdata", d, slot_wdata);
      acc(0, 2, 0);
      chk("doc_read", d, host_rdata);
      acc(1, 3, d);
      chk("tape_reg", d, tape_drive_ctrl);
      acc(0, 3, 0);
      chk("tape_read", i[0] ? d : d & TAPE_NORM_MSK, host_rdata);
      for (int k = 0; k < 3; k++) begin
        acc(1, (k == 2) ? OFS_RESERVED : 3'(k), ~d);
        chk("ro_wr_pulse", 8'h00, slot_wr_pulse);
      end
      acc(0, 2, 0);
      chk("doc_kept", d, host_rdata);
    end
    acc(0, 6, 0);
    chk("rsvd_oe", 8'h01, host_rdata_oe_n);
    for (int k = 0; k < 4; k++) begin
      s = (k == 0) ? 3'h1 : (k == 3) ? 3'h7 : 3'(k + 3);
      core_rdata = 8'($urandom);
      acc(0, s, 0);
      chk("core_slot", core_rdata, host_rdata);
      chk("rd_pulse", 8'h01 << s, slot_rd_pulse);
    end
    for (m = 0; m < 3; m++) begin
      {ident_select, encoding_mode_select} = (m == 0) ? 2'b11 : (m == 1) ? 2'b01 : 2'b00;
      dor_v = 8'($urandom);
      acc(1, 2, dor_v);
      if (m == 2) acc(0, 7, 0);
      for (int j = 0; j < 6; j++) begin
        {core_irq, core_drq, core_dir, core_side, core_density_hi} = 5'($urandom);
        {terminal_count_in, force_wp_en, force_wp_val} = 3'($urandom);
        core_step = (m == 1) ? 1'($urandom) : 1'b0;
        lvl = 4'($urandom);
        load = 1;
        tick(1);
        load = 0;
        tick(2);
        rd_sra("sra_mode");
        chk("irq_out", core_irq, floppy_irq_out);
        chk("tc_pol", (m == 1) ? !terminal_count_in : terminal_count_in, tc_asserted);
        chk("dens_pol", (m == 0) ? core_density_hi : !core_density_hi, density_select_out);
        chk("irq_oe", (m == 1) ? 1'b0 : !dor_v[DOC_DMAEN], floppy_irq_oe_n);
        chk("drq_oe", (m == 1) ? 1'b0 : !dor_v[DOC_DMAEN], dma_req_oe_n);
        chk("drq_out", core_drq, dma_req_out);
        chk("side_out", core_side, head_side_select);
      end
    end
    m = 2;
    core_step = 1;
    tick(3);
    core_step = 0;
    exp_latch = 1;
    tick(2);
    rd_sra("step_set");
    chk("latch_pin", 8'h01, step_latched);
    acc(0, 7, 0);
    chk("latch_clr", 8'h00, step_latched);
    exp_latch = 0;
    rd_sra("step_clear");
    {core_irq, core_drq, core_dir, core_side, force_wp_en} = 0;
    rst = 1;
    tick(2);
    rst = 0;
    chk("rerst_doc", DIG_OUT_RST, digital_output_ctrl);
    rd_sra("sra_m30_rst");
    m = 1;
    {ident_select, encoding_mode_select} = 2'b01;
    rd_sra("sra_ps2_rst");
    close_out();
  end
endmodule : floppy_host_register_modes_tb

`default_nettype wire
